/* File: src/agen_pkg.sv */
// Constants and types for the modulo and bit-reversed address generator.
// How it works
// - Modulo correction applies to pointers from any working register.
// - Bound test uses greater/less than, so overshooting steps still wrap.
// - Corrected address written back only for pre- or post-modify modes.
// - Register-plus-offset mode corrects the address, pointer stays unchanged.
// - Bit reversal exists only in the X write unit, writes only.
// - Only the modifier is bit-reversed; pointer and result stay normal.
// - Reversal needs select not 15, enable set, pre/post increment mode.
// - Modifier is a 15-bit field, scaled to byte addresses for words.
// - Byte access or other modes fall back to a normal address.
// - Active reversal adds pointer and modifier, ignoring the mode offset.
// - Reversed addresses always have bit zero cleared.
// - Reversal beats modulo in the write unit; read unit keeps modulo.
package agen_pkg;

    localparam int ADDR_W = 16;
    localparam int MOD_W = 15;
    localparam logic [3:0] STACK_SEL = 4'hf;
    localparam int ENABLE_BIT = 15;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFF_REVCTL = 4'h0;
    localparam logic [3:0] OFF_MODCTL = 4'h1;
    localparam logic [3:0] OFF_XSTART = 4'h2;
    localparam logic [3:0] OFF_XEND = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;

    localparam logic [15:0] RST_REVCTL = 16'h0000;
    localparam logic [15:0] RST_MODCTL = 16'h000f;
    localparam logic [15:0] RST_BOUND = 16'h0000;

    // Address mode control fields.
    localparam int MC_XEN_BIT = 15;
    localparam int MC_SEL_LSB = 0;

    typedef enum logic [2:0] {
        MODE_DIRECT,
        MODE_POSTINC,
        MODE_POSTDEC,
        MODE_PREINC,
        MODE_PREDEC,
        MODE_OFFSET
    } amode_e;

endpackage

/* File: src/rev_carry_add.sv */
// Reverse-carry adder: carries ripple from the top bit down to bit zero.
`timescale 1ns/1ps
module rev_carry_add #(
    parameter int W = 16
) (
    // Operands.
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    // Sum.
    output logic [W-1:0] sum
);
    always_comb begin
        logic c;
        c = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            sum[i] = a[i] ^ b[i] ^ c;
            c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
        end
    end
endmodule

/* File: src/modulo_bitrev_address_gen.sv */
// Modulo and bit-reversed effective address generation for X accesses.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module modulo_bitrev_address_gen #(
    parameter int AW = agen_pkg::ADDR_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // Access request from the decoder.
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqByte,
    input wire logic [3:0] reqPtrSel,
    input wire agen_pkg::amode_e reqMode,
    input wire logic [AW-1:0] reqPtr,
    input wire logic [AW-1:0] reqOffset,
    // Results toward the memory bus and register file.
    output logic eaValid,
    output logic [AW-1:0] eaAddr,
    output logic ptrWrEn,
    output logic [3:0] ptrWrSel,
    output logic [AW-1:0] ptrWrData,
    output logic eaReversed
);
    import agen_pkg::*;

    logic [15:0] revCtl_r;
    logic [15:0] modCtl_r;
    logic [AW-1:0] xStart_r;
    logic [AW-1:0] xEnd_r;
    logic [7:0] revCount_r;

    wire logic revEnable = revCtl_r[ENABLE_BIT];
    wire logic [MOD_W-1:0] revMod = revCtl_r[MOD_W-1:0];
    wire logic modEnable = modCtl_r[MC_XEN_BIT];
    wire logic [3:0] revSel = modCtl_r[MC_SEL_LSB +: 4];

    // Register writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            revCtl_r <= RST_REVCTL;
            modCtl_r <= RST_MODCTL;
            xStart_r <= AW'(RST_BOUND);
            xEnd_r <= AW'(RST_BOUND);
        end else if (regWr) begin
            case (regAddr)
                OFF_REVCTL: revCtl_r <= regWdata;
                OFF_MODCTL: modCtl_r <= regWdata;
                OFF_XSTART: xStart_r <= AW'(regWdata);
                OFF_XEND: xEnd_r <= AW'(regWdata);
                default: ;
            endcase
        end
    end

    // Register reads, answered one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                OFF_REVCTL: regRdata <= revCtl_r;
                OFF_MODCTL: regRdata <= modCtl_r;
                OFF_XSTART: regRdata <= 16'(xStart_r);
                OFF_XEND: regRdata <= 16'(xEnd_r);
                OFF_STATUS: regRdata <= {8'h00, revCount_r};
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    function automatic logic isIncMode(input amode_e m);
        return (m == MODE_PREINC) || (m == MODE_POSTINC);
    endfunction

    function automatic logic isModify(input amode_e m);
        return (m == MODE_PREINC) || (m == MODE_POSTINC) ||
               (m == MODE_PREDEC) || (m == MODE_POSTDEC);
    endfunction

    // Bit reversal only for word writes through pre/post increment.
    // Select and enable come straight from the registers, so a control
    // write already governs the very next request; no gap is enforced here.
    logic revActive;
    always_comb begin
        revActive = revEnable && (reqPtrSel == revSel) &&
                    (revSel != STACK_SEL) && isIncMode(reqMode) &&
                    reqWrite && !reqByte;
    end

    // The modifier is scaled to bytes; only it is reversed in sense.
    logic [AW-1:0] revModBytes;
    logic [AW-1:0] revSum;
    assign revModBytes = AW'({revMod, 1'b0});

    rev_carry_add #(.W(AW)) uRev (
        .a({reqPtr[AW-1:1], 1'b0}),
        .b(revModBytes),
        .sum(revSum)
    );

    // Normal arithmetic and modulo correction.
    logic [AW-1:0] stepAmt;
    logic [AW-1:0] modified;
    logic [AW-1:0] corrected;
    logic [AW-1:0] eaNext;
    logic [AW-1:0] ptrNext;
    logic modApplies;
    logic isDec;
    always_comb begin
        stepAmt = reqByte ? AW'(1) : AW'(2);
        isDec = (reqMode == MODE_PREDEC) || (reqMode == MODE_POSTDEC);
        case (reqMode)
            MODE_POSTINC, MODE_PREINC: modified = reqPtr + stepAmt;
            MODE_POSTDEC, MODE_PREDEC: modified = reqPtr - stepAmt;
            MODE_OFFSET: modified = reqPtr + reqOffset;
            default: modified = reqPtr;
        endcase
        // Any register qualifies; disabled by active reversal on writes.
        modApplies = modEnable && !revActive;
        corrected = modified;
        if (modApplies && reqMode != MODE_DIRECT) begin
            // Overshoot past a bound wraps by the buffer length.
            if (!isDec && modified > xEnd_r) begin
                corrected = modified - (xEnd_r - xStart_r + AW'(1));
            end else if (isDec && modified < xStart_r) begin
                corrected = modified + (xEnd_r - xStart_r + AW'(1));
            end
        end
        if (revActive) begin
            // Mode offset ignored and bit zero cleared.
            // A carry that ripples down into bit zero is dropped: words only.
            ptrNext = {revSum[AW-1:1], 1'b0};
            eaNext = (reqMode == MODE_PREINC) ? ptrNext :
                     {reqPtr[AW-1:1], 1'b0};
        end else begin
            eaNext = (reqMode == MODE_POSTINC ||
                      reqMode == MODE_POSTDEC) ? reqPtr : corrected;
            ptrNext = corrected;
        end
    end

    // Registered results.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eaValid <= 1'b0;
            eaAddr <= '0;
            ptrWrEn <= 1'b0;
            ptrWrSel <= 4'h0;
            ptrWrData <= '0;
            eaReversed <= 1'b0;
        end else begin
            eaValid <= reqValid;
            eaAddr <= eaNext;
            ptrWrEn <= reqValid && isModify(reqMode);
            ptrWrSel <= reqPtrSel;
            ptrWrData <= ptrNext;
            eaReversed <= reqValid && revActive;
        end
    end

    // Count of reversed accesses, visible in the status register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            revCount_r <= 8'h00;
        end else if (reqValid && revActive) begin
            revCount_r <= revCount_r + 8'h01;
        end
    end

    // Assertions.
    property p_rev_lsb;
        @(posedge clk) disable iff (!rst_n)
        eaReversed |-> (eaAddr[0] == 1'b0 && ptrWrData[0] == 1'b0);
    endproperty
    a_rev_lsb: assert property (p_rev_lsb)
        else $error("Reversed address has bit zero set.");

    property p_rev_write_only;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && !reqWrite) |=> !eaReversed;
    endproperty
    a_rev_write_only: assert property (p_rev_write_only)
        else $error("Reversal applied to a read.");

    property p_rev_stack;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqPtrSel == STACK_SEL) |=> !eaReversed;
    endproperty
    a_rev_stack: assert property (p_rev_stack)
        else $error("Reversal applied to the stack pointer.");

    property p_rev_sel;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqPtrSel != revSel) |=> !eaReversed;
    endproperty
    a_rev_sel: assert property (p_rev_sel)
        else $error("Reversal applied to an unselected pointer.");

    property p_rev_byte;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqByte) |=> !eaReversed;
    endproperty
    a_rev_byte: assert property (p_rev_byte)
        else $error("Reversal applied to a byte access.");

    property p_offset_no_wb;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqMode == MODE_OFFSET) |=> !ptrWrEn;
    endproperty
    a_offset_no_wb: assert property (p_offset_no_wb)
        else $error("Offset mode wrote the pointer back.");

    property p_modify_wb;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && isModify(reqMode)) |=>
            (ptrWrEn && ptrWrSel == $past(reqPtrSel));
    endproperty
    a_modify_wb: assert property (p_modify_wb)
        else $error("Modify mode did not write the pointer back.");

    property p_rev_when;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && revEnable && reqWrite && !reqByte &&
         reqPtrSel == revSel && revSel != STACK_SEL &&
         reqMode == MODE_POSTINC) |=>
            (eaReversed && ptrWrData[AW-1:1] == $past(revSum[AW-1:1]));
    endproperty
    a_rev_when: assert property (p_rev_when)
        else $error("Qualified access was not reversed.");

    property p_rev_no_modulo;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && revActive && modEnable) |=>
            (ptrWrData[AW-1:1] == $past(revSum[AW-1:1]));
    endproperty
    a_rev_no_modulo: assert property (p_rev_no_modulo)
        else $error("Modulo correction touched a reversed write.");

    property p_rev_preinc;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && revActive && reqMode == MODE_PREINC) |=>
            (eaAddr == ptrWrData);
    endproperty
    a_rev_preinc: assert property (p_rev_preinc)
        else $error("Reversed pre-increment address is wrong.");

    property p_rev_post;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && revActive && reqMode == MODE_POSTINC) |=>
            (eaAddr[AW-1:1] == $past(reqPtr[AW-1:1]));
    endproperty
    a_rev_post: assert property (p_rev_post)
        else $error("Reversed post-increment did not use the pointer.");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_n)
        !reqValid |=> (!eaValid && !ptrWrEn && !eaReversed);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("Result strobes rose without a request.");

    property p_mod_wrap;
        @(posedge clk) disable iff (!rst_n)
        // Only a pointer that starts inside the buffer is held to it; one
        // outside is moved by one length and may well stay outside.
        (reqValid && !revActive && modEnable && xStart_r < xEnd_r &&
         reqPtr >= xStart_r && reqPtr <= xEnd_r &&
         isIncMode(reqMode) && reqPtr + stepAmt > xEnd_r) |=>
            (ptrWrData <= $past(xEnd_r) && ptrWrData >= $past(xStart_r));
    endproperty
    a_mod_wrap: assert property (p_mod_wrap)
        else $error("Incrementing pointer passed the upper bound.");

    property p_dec_wrap;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && !revActive && modEnable && xStart_r < xEnd_r &&
         xStart_r > AW'(1) && reqPtr >= xStart_r && reqPtr <= xEnd_r &&
         isDec) |=>
            (ptrWrData <= $past(xEnd_r) && ptrWrData >= $past(xStart_r));
    endproperty
    a_dec_wrap: assert property (p_dec_wrap)
        else $error("Decrementing pointer passed the lower bound.");

    property p_reset_off;
        @(posedge clk) !rst_n |=> (!revEnable && revMod == '0);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("Reset left bit reversal configured.");

    c_rev: cover property (@(posedge clk) disable iff (!rst_n)
        eaReversed);
    c_offset: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && reqMode == MODE_OFFSET && modEnable);
    c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && modApplies && corrected != modified);
    c_dec_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && isDec && modApplies && corrected != modified);
    c_rev_mod: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && revActive && modEnable);

endmodule

/* File: tb/decoder_model.sv */
// Decoder-side model that presents one access request per call.
`timescale 1ns/1ps
module decoder_model (
    // Clock.
    input wire logic clk,
    // Request toward the address generator.
    output logic reqValid,
    output logic reqWrite,
    output logic reqByte,
    output logic [3:0] reqPtrSel,
    output agen_pkg::amode_e reqMode,
    output logic [15:0] reqPtr,
    output logic [15:0] reqOffset
);
    import agen_pkg::*;

    initial begin
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqByte = 1'b0;
        reqPtrSel = 4'h0;
        reqMode = MODE_DIRECT;
        reqPtr = 16'h0000;
        reqOffset = 16'h0000;
    end

    // Idle cycles carry inverted operands, so sampling outside a request
    // shows up as a wrong address instead of a lucky match.
    task automatic issue(input logic w, b, input logic [3:0] s,
            input amode_e m, input logic [15:0] p, o);
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqByte <= b;
        reqPtrSel <= s;
        reqMode <= m;
        reqPtr <= p;
        reqOffset <= o;
        @(posedge clk);
        reqValid <= 1'b0;
        reqPtr <= ~p;
        reqOffset <= ~o;
    endtask
endmodule

/* File: tb/tb_modulo_bitrev_address_gen.sv */
// Self-checking bench for the modulo and bit-reversed address generator.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %h got %h", nm, e, g); bad_count++; end end
module tb_modulo_bitrev_address_gen;
    import agen_pkg::*;
    localparam logic [15:0] BSTART = 16'h1000;
    localparam logic [15:0] BEND = 16'h101f;
    localparam logic [15:0] LEN = 16'h0020;
    localparam logic [15:0] CFG_MOD [4] = '{16'h8003, 16'h8003, 16'h0003,
                                           16'h800f};
    localparam logic [3:0] CFG_REV = 4'b1110;
    logic clk, rst_n, regWr, regRd, reqValid, reqWrite, reqByte;
    logic [3:0] regAddr, reqPtrSel, ptrWrSel;
    logic [15:0] regWdata, regRdata, reqPtr, reqOffset, eaAddr, ptrWrData;
    amode_e reqMode;
    logic eaValid, ptrWrEn, eaReversed, eWe, eRv;
    logic [15:0] modCtl, revCtl, eEa, eWd;
    logic [31:0] r;
    int seed = 77;
    int bad_count = 0;
    int cmp_count = 0;
    int revCount = 0;

    modulo_bitrev_address_gen dut (.clk, .rst_n, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .reqValid, .reqWrite, .reqByte, .reqPtrSel,
        .reqMode, .reqPtr, .reqOffset, .eaValid, .eaAddr, .ptrWrEn,
        .ptrWrSel, .ptrWrData, .eaReversed);
    decoder_model u_dec (.clk, .reqValid, .reqWrite, .reqByte, .reqPtrSel,
        .reqMode, .reqPtr, .reqOffset);

    function automatic logic [15:0] rca(input logic [15:0] a, b);
        logic [15:0] ra, rb, s;
        for (int i = 0; i < 16; i++) begin
            ra[i] = a[15-i];
            rb[i] = b[15-i];
        end
        s = ra + rb;
        for (int i = 0; i < 16; i++) begin
            rca[i] = s[15-i];
        end
    endfunction

    function automatic void model(input logic w, b, input logic [3:0] s,
            input amode_e m, input logic [15:0] p, o);
        logic inc, dec;
        logic [15:0] nx;
        inc = m == MODE_POSTINC || m == MODE_PREINC;
        dec = m == MODE_POSTDEC || m == MODE_PREDEC;
        eRv = w && !b && inc && s == modCtl[3:0] && s != STACK_SEL
            && revCtl[ENABLE_BIT];
        nx = dec ? p - (b ? 16'h1 : 16'h2)
            : (m == MODE_OFFSET ? p + o : p + (b ? 16'h1 : 16'h2));
        if (modCtl[MC_XEN_BIT] && !eRv) begin
            if (dec && nx < BSTART) begin
                nx = nx + LEN;
            end else if (!dec && nx > BEND) begin
                nx = nx - LEN;
            end
        end
        if (eRv) begin
            nx = rca(p, {revCtl[14:0], 1'b0}) & 16'hfffe;
        end
        eWe = inc || dec;
        eWd = nx;
        eEa = (m == MODE_PREINC || m == MODE_PREDEC || m == MODE_OFFSET)
            ? nx : p;
        if (eRv) begin
            eEa = (m == MODE_PREINC) ? nx : p & 16'hfffe;
        end
    endfunction

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK("regRdata", e, regRdata)
    endtask

    task automatic access(input logic w, b, input logic [3:0] s,
            input amode_e m, input logic [15:0] p, o);
        model(w, b, s, m, p, o);
        revCount += eRv;
        u_dec.issue(w, b, s, m, p, o);
        #1;
        `CHK("eaValid", 1'b1, eaValid)
        `CHK("eaAddr", eEa, eaAddr)
        `CHK("ptrWrEn", eWe, ptrWrEn)
        `CHK("eaReversed", eRv, eaReversed)
        if (eWe) `CHK("ptrWrData", eWd, ptrWrData)
        if (eWe) `CHK("ptrWrSel", s, ptrWrSel)
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            reg_chk(i[3:0], i == 1 ? RST_MODCTL
                : (i == 2 || i == 3) ? RST_BOUND : RST_REVCTL);
        end
        reg_wr(OFF_XSTART, BSTART);
        reg_wr(OFF_XEND, BEND);
        reg_chk(OFF_XEND, BEND);
        for (int c = 0; c < 4; c++) begin
            r = $random(seed);
            modCtl = CFG_MOD[c];
            revCtl = CFG_REV[c] ? {1'b1, r[14:0]} : 16'h0000;
            reg_wr(OFF_MODCTL, modCtl);
            reg_wr(OFF_REVCTL, revCtl);
            reg_chk(OFF_REVCTL, revCtl);
            @(posedge clk);
            access(1'b1, 1'b0, modCtl[3:0], MODE_PREINC, BSTART, 16'h0);
            access(1'b0, 1'b0, 4'h2, MODE_OFFSET, BEND, 16'h001f);
            for (int k = 0; k < 32; k++) begin
                r = $random(seed);
                access(r[6], r[7], r[5] ? modCtl[3:0] : r[11:8],
                    amode_e'(r[14:12] % 3'd6), BSTART + r[4:0],
                    {11'h000, r[20:16]});
            end
        end
        reg_wr(OFF_STATUS, 16'hffff);
        reg_chk(OFF_STATUS, {8'h00, revCount[7:0]});
        reg_wr(4'h5, 16'hffff);
        reg_chk(4'h5, 16'h0000);
        // A second reset must drop the reversal set up by the last pass.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_chk(OFF_REVCTL, RST_REVCTL);
        reg_chk(OFF_MODCTL, RST_MODCTL);
        end_sim();
    end
endmodule
